/* File: hdl/eag_defs.svh */
`ifndef EAG_DEFS_SVH
`define EAG_DEFS_SVH

// word and address widths
`define EAG_WORD_W 24
`define EAG_ADDR_W 15
`define EAG_OPCODE_W 10

// instruction field positions
`define EAG_OPCODE_MSB 23
`define EAG_OPCODE_LSB 14
`define EAG_INDEX_MSB 17
`define EAG_INDEX_LSB 15
`define EAG_REL_BIT 14
`define EAG_SIGN_BIT 13
`define EAG_OPERAND_MSB 13

// fitted memory sizes in K words
`define EAG_MEM_16K 16
`define EAG_MEM_24K 24
`define EAG_MEM_32K 32

// reset values
`define EAG_RST_WORD 24'h000000
`define EAG_RST_ADDR 15'h0000
`define EAG_RST_OPCODE 10'h000

`endif

/* File: hdl/eag_pkg.sv */
package eag_pkg;

  // sequence states; fetch is sequence state 1, index is sequence state 2
  typedef enum logic [1:0] {
    EAG_IDLE  = 2'b00,
    EAG_FETCH = 2'b01,
    EAG_INDEX = 2'b10,
    EAG_EXEC  = 2'b11
  } eag_state_t;

endpackage : eag_pkg

/* File: hdl/eag_effective_address_generator.sv */
`timescale 1ns/1ps
`include "eag_defs.svh"
module eag_effective_address_generator
  import eag_pkg::*;
#(
  parameter int MEM_SIZE_K = `EAG_MEM_32K
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // sequence control request
  input wire logic start_in,
  input wire logic fetch_via_i_in,
  input wire logic remote_object_in,
  input wire logic [`EAG_ADDR_W-1:0] pc_in,
  // command class, valid with mem_ready_in during fetch
  input wire logic cmd_generic_in,
  input wire logic cmd_rel_excepted_in,
  input wire logic cmd_index_control_in,
  input wire logic cmd_write_in,
  // core memory address multiplexer
  output logic mem_req_out,
  output logic mem_write_out,
  output logic [`EAG_ADDR_W-1:0] mem_addr_out,
  input wire logic mem_ready_in,
  input wire logic [`EAG_WORD_W-1:0] mem_data_in,
  // datapath view
  output logic [`EAG_WORD_W-1:0] b_reg_out,
  output logic [`EAG_OPCODE_W-1:0] opcode_out,
  output logic [`EAG_ADDR_W-1:0] operand_out,
  output logic relative_flag_out,
  output logic [1:0] seq_state_out,
  output logic addr_from_index_bits_out,
  output logic b_to_adder_gate_out,
  output logic sum_to_operand_gate_out,
  output logic sign_extend_to_bit14_out,
  output logic zero_region_out,
  // completion
  output logic [`EAG_WORD_W-1:0] exec_data_out,
  output logic done_out
);

  logic rst_meta;
  logic rst_n;
  eag_state_t state;
  eag_state_t next_state;
  logic [`EAG_ADDR_W-1:0] base;
  logic write_pend;
  logic [`EAG_ADDR_W-1:0] rel_sum;
  logic [`EAG_WORD_W-1:0] idx_sum;
  logic [2:0] index_sel;
  logic rel_take;
  logic rel_add;
  logic idx_take;
  logic [`EAG_ADDR_W-1:0] next_operand;
  logic [`EAG_ADDR_W-1:0] next_addr;
  logic next_req;
  logic next_write;
  logic next_zero;

  // only the bits the fitted core needs reach memory; 16K drops bit 14
  function automatic logic [`EAG_ADDR_W-1:0] fit_addr(input logic [`EAG_ADDR_W-1:0] a);
    if (MEM_SIZE_K == `EAG_MEM_16K) begin
      fit_addr = {1'b0, a[`EAG_ADDR_W-2:0]};
    end else begin
      fit_addr = a;
    end
  endfunction : fit_addr

  // 24K fitted: top 8K block does not exist
  function automatic logic in_zero_block(input logic [`EAG_ADDR_W-1:0] a);
    in_zero_block = (MEM_SIZE_K == `EAG_MEM_24K) && (a[14:13] == 2'b11);
  endfunction : in_zero_block

  // reset release through two flops
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // index selection from the fetched word
  always_comb begin
    index_sel = mem_data_in[`EAG_INDEX_MSB:`EAG_INDEX_LSB];
    // control-type commands keep bits 15-17 away from the adder
    idx_take = (index_sel != 3'h0) && !cmd_index_control_in;
  end

  // relative adder
  always_comb begin
    rel_take = mem_data_in[`EAG_REL_BIT] && !cmd_generic_in;
    rel_add = rel_take && !cmd_rel_excepted_in;
    // sign of operand fills adder bit 14; 15-bit wrap gives +8191..-8192
    rel_sum = {mem_data_in[`EAG_SIGN_BIT], mem_data_in[`EAG_OPERAND_MSB:0]} + base;
  end

  // index adder
  always_comb begin
    // whole index word enters adder; only sum bits 14-0 are kept
    idx_sum = mem_data_in + {{(`EAG_WORD_W-`EAG_ADDR_W){1'b0}}, operand_out};
  end

  // next state and next memory address
  always_comb begin
    next_state = state;
    next_operand = operand_out;
    next_addr = mem_addr_out;
    next_req = mem_req_out;
    next_write = mem_write_out;
    next_zero = zero_region_out;
    case (state)
      EAG_IDLE: begin
        if (start_in) begin
          next_state = EAG_FETCH;
          // branch targets and remote objects are fetched via I
          next_addr = fit_addr((fetch_via_i_in || remote_object_in) ? operand_out : pc_in);
          next_req = 1'b1;
          next_write = 1'b0;
          next_zero = 1'b0;
        end
      end
      EAG_FETCH: begin
        if (mem_ready_in) begin
          if (rel_add) begin
            next_operand = rel_sum;
          end else begin
            next_operand = {1'b0, mem_data_in[`EAG_OPERAND_MSB:0]};
          end
          if (idx_take) begin
            next_state = EAG_INDEX;
            next_addr = {{(`EAG_ADDR_W-3){1'b0}}, index_sel};
            next_req = 1'b1;
            next_write = 1'b0;
            next_zero = 1'b0;
          end else begin
            next_state = EAG_EXEC;
            next_addr = fit_addr(next_operand);
            next_zero = in_zero_block(next_operand);
            next_req = !in_zero_block(next_operand);
            next_write = cmd_write_in;
          end
        end
      end
      EAG_INDEX: begin
        if (mem_ready_in) begin
          next_operand = idx_sum[`EAG_ADDR_W-1:0];
          // direction was decoded at fetch; the index read must not lose it
          next_write = write_pend;
          next_state = EAG_EXEC;
          next_addr = fit_addr(next_operand);
          next_zero = in_zero_block(next_operand);
          next_req = !in_zero_block(next_operand);
        end
      end
      EAG_EXEC: begin
        if (zero_region_out || mem_ready_in) begin
          next_state = EAG_IDLE;
          next_req = 1'b0;
          next_write = 1'b0;
          next_zero = 1'b0;
        end
      end
      default: begin
        next_state = EAG_IDLE;
        next_req = 1'b0;
        next_write = 1'b0;
        next_zero = 1'b0;
      end
    endcase
  end

  // sequence state, mirrored on a port for the datapath
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= EAG_IDLE;
      seq_state_out <= 2'h0;
    end else begin
      state <= next_state;
      seq_state_out <= next_state;
    end
  end

  // memory request, held until the core answers
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mem_req_out <= 1'b0;
      mem_write_out <= 1'b0;
      mem_addr_out <= `EAG_RST_ADDR;
    end else begin
      mem_req_out <= next_req;
      mem_write_out <= next_write;
      mem_addr_out <= next_addr;
    end
  end

  // absent block flag, level through the execute access
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      zero_region_out <= 1'b0;
    end else begin
      zero_region_out <= next_zero;
    end
  end

  // command class inputs stand only at fetch, so the direction is kept here
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      write_pend <= 1'b0;
    end else if (state == EAG_FETCH && mem_ready_in) begin
      write_pend <= cmd_write_in;
    end
  end

  // relative base latched at start; a taken branch fetched via I still uses P
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      base <= `EAG_RST_ADDR;
    end else if (state == EAG_IDLE && start_in) begin
      base <= remote_object_in ? operand_out : pc_in;
    end
  end

  // B holds the fetched instruction, then the index word
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      b_reg_out <= `EAG_RST_WORD;
    end else if (state == EAG_FETCH && mem_ready_in) begin
      b_reg_out <= mem_data_in;
    end else if (state == EAG_INDEX && mem_ready_in) begin
      b_reg_out <= mem_data_in;
    end
  end

  // I op field and relative flag, decoded from B 23-14
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      opcode_out <= `EAG_RST_OPCODE;
      relative_flag_out <= 1'b0;
    end else if (state == EAG_FETCH && mem_ready_in) begin
      opcode_out <= mem_data_in[`EAG_OPCODE_MSB:`EAG_OPCODE_LSB];
      // flag set for excepted commands too; only the add is withheld
      relative_flag_out <= rel_take;
    end
  end

  // I operand: raw operand, relative sum, then index sum
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      operand_out <= `EAG_RST_ADDR;
    end else begin
      operand_out <= next_operand;
    end
  end

  // gate strobes lag the transfer they name by one cycle; the index cell addressing level rises with state 2, without lag
  // index cell addressing, level through state 2
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      addr_from_index_bits_out <= 1'b0;
    end else begin
      addr_from_index_bits_out <= (next_state == EAG_INDEX);
    end
  end

  // index word into the adder
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      b_to_adder_gate_out <= 1'b0;
    end else begin
      b_to_adder_gate_out <= (state == EAG_INDEX) && mem_ready_in;
    end
  end

  // any sum written back into the operand field
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sum_to_operand_gate_out <= 1'b0;
    end else begin
      sum_to_operand_gate_out <= mem_ready_in &&
        ((state == EAG_INDEX) || (state == EAG_FETCH && rel_add));
    end
  end

  // operand sign carried into adder bit 14
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sign_extend_to_bit14_out <= 1'b0;
    end else begin
      sign_extend_to_bit14_out <= (state == EAG_FETCH) && mem_ready_in && rel_add;
    end
  end

  // execute data; missing block reads as zero, a write leaves it alone
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      exec_data_out <= `EAG_RST_WORD;
    end else if (state == EAG_EXEC && zero_region_out) begin
      exec_data_out <= `EAG_RST_WORD;
    end else if (state == EAG_EXEC && mem_ready_in && !mem_write_out) begin
      exec_data_out <= mem_data_in;
    end
  end

  // completion pulse; the absent block never answers, so it ends on its own
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      done_out <= 1'b0;
    end else begin
      done_out <= (state == EAG_EXEC) && (zero_region_out || mem_ready_in);
    end
  end

endmodule : eag_effective_address_generator

/* File: testbench/eag_checker_sva.sv */
`timescale 1ns/1ps
module eag_checker #(
  parameter int MEM_SIZE_K = 32
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // memory side
  input wire logic mem_req_out,
  input wire logic mem_ready_in,
  input wire logic [14:0] mem_addr_out,
  // datapath view
  input wire logic [9:0] opcode_out,
  input wire logic [14:0] operand_out,
  input wire logic relative_flag_out,
  input wire logic [1:0] seq_state_out,
  input wire logic addr_from_index_bits_out,
  input wire logic b_to_adder_gate_out,
  input wire logic sum_to_operand_gate_out,
  input wire logic sign_extend_to_bit14_out,
  input wire logic zero_region_out,
  input wire logic done_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_index_entry: assert property (
    seq_state_out == 2'd2 && $past(seq_state_out) == 2'd1 |-> opcode_out[3:1] != 3'h0)
    else $error("index state without index bits");
  a_index_addr: assert property (
    addr_from_index_bits_out |-> seq_state_out == 2'd2 && mem_addr_out == {12'h0, opcode_out[3:1]})
    else $error("index cell address wrong");
  a_index_gate: assert property (
    b_to_adder_gate_out |-> sum_to_operand_gate_out && $past(seq_state_out) == 2'd2)
    else $error("index add outside index state");
  a_rel_state: assert property (
    sign_extend_to_bit14_out |-> relative_flag_out && $past(seq_state_out) == 2'd1)
    else $error("relative add outside fetch");
  a_rel_flag: assert property (
    relative_flag_out |-> opcode_out[0]) else $error("relative flag without bit 14");
  a_req_hold: assert property (
    mem_req_out && !mem_ready_in |=> mem_req_out && $stable(mem_addr_out))
    else $error("request dropped or moved");
  a_exec_addr: assert property (
    seq_state_out == 2'd3 && mem_req_out |->
      mem_addr_out == ((MEM_SIZE_K == 16) ? {1'b0, operand_out[13:0]} : operand_out))
    else $error("execute address not operand");
  a_wrap_mask: assert property (
    mem_req_out |-> (MEM_SIZE_K == 16) ? !mem_addr_out[14]
      : (MEM_SIZE_K != 24 || mem_addr_out < 15'h6000)) else $error("address not masked");
  a_zero_done: assert property (
    $rose(zero_region_out) |-> !mem_req_out ##[0:2] done_out) else $error("absent block access");
  cover property (b_to_adder_gate_out);
  cover property (sign_extend_to_bit14_out);
  cover property ($rose(zero_region_out));
endmodule : eag_checker

bind eag_effective_address_generator eag_checker #(.MEM_SIZE_K(MEM_SIZE_K)) eag_checker_i (
  .clk_in, .reset_n_in, .mem_req_out, .mem_ready_in, .mem_addr_out, .opcode_out,
  .operand_out, .relative_flag_out, .seq_state_out, .addr_from_index_bits_out,
  .b_to_adder_gate_out, .sum_to_operand_gate_out, .sign_extend_to_bit14_out,
  .zero_region_out, .done_out);

/* File: testbench/eag_mem_model.sv */
`timescale 1ns/1ps
module eag_mem_model (
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic write_in,
  input wire logic [14:0] addr_in,
  output logic ready_out,
  output logic [23:0] data_out
);
  logic [23:0] cells [0:32767];
  logic [14:0] last_addr;
  logic last_write = 1'b0;
  int wait_cnt = 0;
  initial begin
    ready_out = 1'b0;
    data_out = 24'h000000;
    for (int i = 0; i < 32768; i++) cells[i] = 24'(i * 7);
  end
  // zero to two wait cycles; data toggles outside the ready cycle
  always @(posedge clk_in) begin
    if (req_in && !ready_out && wait_cnt == 0) begin
      ready_out <= 1'b1;
      data_out <= cells[addr_in];
      last_addr <= addr_in;
      last_write <= write_in;
      wait_cnt <= $urandom_range(2, 0);
    end else begin
      if (req_in && !ready_out) wait_cnt <= wait_cnt - 1;
      ready_out <= 1'b0;
      data_out <= ~data_out;
    end
  end
endmodule : eag_mem_model

/* File: testbench/effective_address_generator_tb_top.sv */
`timescale 1ns/1ps
module effective_address_generator_tb_top;
  import eag_pkg::*;
  logic clk_in = 0, reset_n_in = 0, start_in = 0, fetch_via_i_in = 0, remote_object_in = 0;
  logic cmd_generic_in = 0, cmd_rel_excepted_in = 0, cmd_index_control_in = 0;
  logic cmd_write_in = 0, mem_ready_in, mem_req_out, relative_flag_out, done_out;
  logic mem_write_out;
  logic [14:0] pc_in = 0, mem_addr_out, operand_out, last_ea = 0;
  logic [23:0] mem_data_in, exec_data_out, last_data = 0;
  int err_count = 0, comparisons = 0, cyc = 0;
  always #20 clk_in = ~clk_in;
  eag_effective_address_generator #(.MEM_SIZE_K(24)) eag_effective_address_generator_i (
    .clk_in, .reset_n_in, .start_in, .fetch_via_i_in, .remote_object_in, .pc_in,
    .cmd_generic_in, .cmd_rel_excepted_in, .cmd_index_control_in, .cmd_write_in,
    .mem_req_out, .mem_write_out, .mem_addr_out, .mem_ready_in, .mem_data_in,
    .b_reg_out(), .opcode_out(), .operand_out, .relative_flag_out, .seq_state_out(),
    .addr_from_index_bits_out(), .b_to_adder_gate_out(), .sum_to_operand_gate_out(),
    .sign_extend_to_bit14_out(), .zero_region_out(), .exec_data_out, .done_out);
  eag_mem_model mem_i (.clk_in(clk_in), .req_in(mem_req_out), .write_in(mem_write_out),
    .addr_in(mem_addr_out),
    .ready_out(mem_ready_in), .data_out(mem_data_in));
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic close_out;
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // f: via_i, remote, generic, excepted, index control, write
  task automatic run(input logic [14:0] pc, input logic [23:0] ins, input logic [5:0] f);
    logic [14:0] fa, ea;
    int n;
    if (last_ea >= 15'h6000) f[1:0] = 2'b00;
    fa = (f[0] | f[1]) ? last_ea : pc;
    mem_i.cells[fa] = ins;
    ea = {1'b0, ins[13:0]};
    if (ins[14] && !(f[2] | f[3])) ea = {ins[13], ins[13:0]} + (f[1] ? last_ea : pc);
    if (ins[17:15] != 3'h0 && !f[4]) ea = ea + mem_i.cells[ins[17:15]][14:0];
    if (ea >= 15'h6000) last_data = 24'h000000;
    else if (!f[5]) last_data = mem_i.cells[ea];
    @(posedge clk_in);
    start_in <= 1'b1;
    {cmd_write_in, cmd_index_control_in, cmd_generic_in, remote_object_in} <= {f[5:4], f[2:1]};
    fetch_via_i_in <= f[0];
    cmd_rel_excepted_in <= f[3] | f[2];
    pc_in <= pc;
    @(posedge clk_in);
    start_in <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (done_out !== 1'b1 && n < 80);
    check("operand", 24'(operand_out), 24'(ea));
    check("rel_flag", 24'(relative_flag_out), 24'(ins[14] & ~f[2]));
    if (ea < 15'h6000 && !f[5]) check("exec_addr", 24'(mem_i.last_addr), 24'(ea));
    if (ea < 15'h6000) check("exec_write", 24'(mem_i.last_write), 24'(f[5]));
    check("exec_data", exec_data_out, last_data);
    last_ea = ea;
  endtask : run
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      close_out;
    end
  end
  initial begin
    void'($urandom(32'h049c83ce));
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    run(15'h1000, 24'h004000 | 24'h1fff, 6'h00);
    run(15'h1000, 24'h006000, 6'h00);
    run(15'h0010, 24'h007fff, 6'h00);
    run(15'h0200, 24'h03c010, 6'h02);
    run(15'h0300, 24'h038020, 6'h01);
    run(15'h0400, 24'h03c030, 6'h10);
    run(15'h0500, 24'h024100, 6'h08);
    run(15'h0600, 24'h024100, 6'h04);
    run(15'h4100, 24'h000050, 6'h00);
    run(15'h0700, 24'h027000, 6'h20);
    for (int i = 0; i < 60; i++) begin
      run(15'($urandom_range(24575, 8)), 24'($urandom), 6'($urandom));
    end
    close_out;
  end
endmodule : effective_address_generator_tb_top
